// File: src/alcc_top.sv
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module alcc_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // payload from framer
    input wire logic link_activated,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    // payload to framer
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // power state
    output logic low_power_mode
);
    typedef enum logic {TX_IDLE, TX_SEND} alcc_tx_st_t;
    // ========================================
    // bus slave
    logic aw_got_r, w_got_r, wr_en;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r, wmask_r;
    logic wr_hit;
    assign wr_en = aw_got_r && w_got_r && !s_axi_bvalid;
    assign wr_hit = awaddr_r inside {alcc_pkg::OFF_CTRL, alcc_pkg::OFF_IDENT,
        alcc_pkg::OFF_CAP, alcc_pkg::OFF_ENC, alcc_pkg::OFF_WIN,
        alcc_pkg::OFF_STAT};
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wmask_r <= 32'h0000_0000;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= alcc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wmask_r <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
                s_axi_wready <= 1'b0;
            end
            if (wr_en) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? alcc_pkg::RESP_OKAY :
                    alcc_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    // masked write value of one register
    function automatic logic [31:0] merge(logic [31:0] old,
        logic [31:0] d, logic [31:0] m);
        return (old & ~m) | (d & m);
    endfunction
    // ========================================
    // software registers
    alcc_pkg::alcc_ctrl_t ctrl_r;
    logic [15:0] ident_r;
    logic [1:0] cap_r;
    alcc_pkg::alcc_rl_t enc_r, rl_last_r;
    logic [2:0] win_r;
    logic [31:0] wv, ident_wv, enc_wv;
    logic blocked;
    assign wv = merge(32'h0000_0000, wdata_r, wmask_r);
    assign ident_wv = merge({16'h0000, ident_r}, wdata_r, wmask_r);
    // old fields sit where software writes them, bits 22 to 8
    assign enc_wv = merge({9'h000, enc_r, 8'h00}, wdata_r, wmask_r);
    assign blocked = ctrl_r.link_up || ctrl_r.sess;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= alcc_pkg::CTRL_RST;
            ident_r <= alcc_pkg::IDENT_RST;
            cap_r <= alcc_pkg::CAP_RST;
            enc_r <= alcc_pkg::RL_RST;
            win_r <= alcc_pkg::WIN_DEF;
        end else if (wr_en) begin
            unique case (awaddr_r)
                alcc_pkg::OFF_CTRL:
                    if (wmask_r[0]) ctrl_r <= wv[4:2];
                alcc_pkg::OFF_IDENT:
                    ident_r <= ident_wv[15:0];
                alcc_pkg::OFF_CAP:
                    if (wmask_r[0]) cap_r <= wv[1:0];
                alcc_pkg::OFF_ENC:
                    enc_r <= enc_wv[22:8];
                alcc_pkg::OFF_WIN:
                    // window may only be set between two and the default four
                    if (wmask_r[0] && wv[2:0] >= alcc_pkg::WIN_MIN &&
                        wv[2:0] <= alcc_pkg::WIN_DEF) begin
                        win_r <= wv[2:0];
                    end
                default: ;
            endcase
        end
    end
    // ========================================
    // receive decode
    logic rx_first_r, rx_arg_seen_r, rpt_pend_r, rsv_seen_r;
    logic [7:0] rx_hdr_r, rx_arg_r, hdr_now, arg_now;
    logic rx_end, is_activ, rpt_hit, low_hit;
    logic [2:0] cmd_now;
    assign hdr_now = rx_first_r ? rx_data : rx_hdr_r;
    assign arg_now = rx_arg_seen_r ? rx_arg_r : rx_data;
    assign rx_end = rx_valid && rx_last;
    assign is_activ = hdr_now[7:5] == alcc_pkg::ACTIV_PREFIX;
    assign cmd_now = hdr_now[2:0];
    // info flag in hdr_now[INFO_BIT] deliberately unused
    assign rpt_hit = rx_end && is_activ && !blocked &&
        hdr_now[alcc_pkg::RPT_BIT];
    assign low_hit = rx_end && is_activ && !blocked && !rx_first_r &&
        cmd_now == alcc_pkg::CMD_POWER &&
        arg_now == alcc_pkg::PWR_LOW;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_first_r <= 1'b1;
            rx_arg_seen_r <= 1'b0;
            rx_hdr_r <= 8'h00;
            rx_arg_r <= 8'h00;
        end else if (rx_valid) begin
            rx_first_r <= rx_last;
            if (rx_first_r) rx_hdr_r <= rx_data;
            if (!rx_first_r && !rx_arg_seen_r) rx_arg_r <= rx_data;
            rx_arg_seen_r <= !rx_last && !rx_first_r;
        end
    end
    // reliable-link frames decoded whatever came before
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rl_last_r <= alcc_pkg::RL_RST;
        end else if (rx_valid && rx_first_r && rx_data[7]) begin
            rl_last_r <= alcc_pkg::rl_decode(rx_data);
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_power_mode <= 1'b0;
            rsv_seen_r <= 1'b0;
        end else begin
            // leaving low power belongs to an upper layer
            if (low_hit) low_power_mode <= 1'b1;
            if (rx_end && is_activ && !(cmd_now inside
                {alcc_pkg::CMD_READY, alcc_pkg::CMD_IDENT,
                alcc_pkg::CMD_POWER})) begin
                rsv_seen_r <= 1'b1;
            end
        end
    end
    // ========================================
    // transmit sequencer
    alcc_tx_st_t tx_st_r;
    logic [7:0] tbuf_r [0:3];
    logic [7:0] nb [0:3];
    logic [2:0] tlen_r, nlen, tidx_r;
    logic have_last_r, id_pend_r, rdy_pend_r, load, pick_rpt;
    logic [7:0] ctl, capb;
    logic [2:0] ncmd;
    assign pick_rpt = rpt_pend_r && have_last_r;
    assign load = tx_st_r == TX_IDLE && !blocked &&
        (pick_rpt || id_pend_r || rdy_pend_r);
    assign ncmd = id_pend_r ? alcc_pkg::CMD_IDENT : alcc_pkg::CMD_READY;
    assign ctl = {alcc_pkg::ACTIV_PREFIX, 1'b0, ctrl_r.with_cap,
        ncmd};
    assign capb = {alcc_pkg::CAP_RSV, cap_r};
    always_comb begin
        nb = tbuf_r;
        nlen = tlen_r;
        if (!pick_rpt) begin
            nb[0] = ctl;
            nb[1] = id_pend_r ? ident_r[15:8] : capb;
            nb[2] = ident_r[7:0];
            nb[3] = capb;
            nlen = 3'h1 + (id_pend_r ? 3'h2 : 3'h0) +
                (ctrl_r.with_cap ? 3'h1 : 3'h0);
            if (id_pend_r && ctrl_r.with_cap) nb[3] = capb;
            else if (id_pend_r) nb[3] = 8'h00;
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rpt_pend_r <= 1'b0;
            id_pend_r <= 1'b0;
            rdy_pend_r <= 1'b0;
        end else begin
            // a new event beats a clear in the same cycle
            if (rpt_hit) rpt_pend_r <= 1'b1;
            else if (load || blocked) rpt_pend_r <= 1'b0;
            if (link_activated) id_pend_r <= 1'b1;
            else if (wr_en && awaddr_r == alcc_pkg::OFF_CTRL && wv[1])
                id_pend_r <= 1'b1;
            else if ((load && !pick_rpt) || blocked) id_pend_r <= 1'b0;
            if (wr_en && awaddr_r == alcc_pkg::OFF_CTRL && wv[0])
                rdy_pend_r <= 1'b1;
            else if ((load && !pick_rpt && !id_pend_r) || blocked)
                rdy_pend_r <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_st_r <= TX_IDLE;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
            tidx_r <= 3'h0;
            tlen_r <= 3'h0;
            have_last_r <= 1'b0;
            for (int i = 0; i < 4; i++) tbuf_r[i] <= 8'h00;
        end else begin
            unique case (tx_st_r)
                TX_IDLE:
                    if (load) begin
                        tbuf_r <= nb;
                        tlen_r <= nlen;
                        have_last_r <= 1'b1;
                        tx_valid <= 1'b1;
                        tx_data <= nb[0];
                        tx_last <= nlen == 3'h1;
                        tidx_r <= 3'h1;
                        tx_st_r <= TX_SEND;
                    end
                TX_SEND:
                    if (tx_ready && tx_last) begin
                        tx_valid <= 1'b0;
                        tx_last <= 1'b0;
                        tx_st_r <= TX_IDLE;
                    end else if (tx_ready) begin
                        tx_data <= tbuf_r[tidx_r[1:0]];
                        tx_last <= tidx_r == tlen_r - 3'h1;
                        tidx_r <= tidx_r + 3'h1;
                    end
            endcase
        end
    end
    // ========================================
    // register read
    logic [31:0] rd;
    always_comb begin
        unique case (s_axi_araddr)
            alcc_pkg::OFF_CTRL: rd = {27'h0, ctrl_r, 2'h0};
            alcc_pkg::OFF_IDENT: rd = {16'h0000, ident_r};
            alcc_pkg::OFF_CAP: rd = {30'h0, cap_r};
            alcc_pkg::OFF_STAT: rd = {13'h0, rsv_seen_r, have_last_r,
                rl_last_r, tx_st_r == TX_SEND, low_power_mode};
            // nr written by software names next expected frame
            alcc_pkg::OFF_ENC: rd = {9'h0, enc_r,
                alcc_pkg::rl_encode(enc_r)};
            alcc_pkg::OFF_WIN: rd = {29'h0, win_r};
            default: rd = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= alcc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd;
            s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0 &&
                s_axi_araddr <= alcc_pkg::OFF_WIN) ?
                alcc_pkg::RESP_OKAY : alcc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    // ========================================
    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    tx_rpt_zero_a: assert property (
        load |=> tx_data[alcc_pkg::RPT_BIT] == 1'b0 &&
        tx_data[7:5] == alcc_pkg::ACTIV_PREFIX)
        else $error("activation frame sent with repeat flag");
    tx_blocked_a: assert property (
        blocked && tx_st_r == TX_IDLE |=> !tx_valid)
        else $error("activation frame sent after link up");
    rpt_cause_a: assert property (
        $rose(rpt_pend_r) |-> $past(rpt_hit))
        else $error("resend without repeat request");
    rpt_send_a: assert property (
        rpt_hit && have_last_r && tx_st_r == TX_IDLE |=>
        ##[0:1] (tx_valid && tx_data == tbuf_r[0]))
        else $error("repeat request not served");
    low_pwr_a: assert property (
        low_hit |=> low_power_mode [*2])
        else $error("low power request missed");
    cap_rsv_a: assert property (
        tx_valid && tx_last && tbuf_r[0][alcc_pkg::INFO_BIT] |->
        tx_data[7:2] == alcc_pkg::CAP_RSV)
        else $error("capability reserved bits nonzero");
    rl_round_a: assert property (
        rx_valid && rx_first_r && rx_data[7] |=>
        alcc_pkg::rl_encode(rl_last_r) == $past(rx_data))
        else $error("control byte decode mismatch");
    sup_nons_a: assert property (
        rl_last_r.kind != alcc_pkg::K_INFO |-> rl_last_r.ns == 3'h0)
        else $error("sequence number outside info frame");
    ident_auto_a: assert property (
        link_activated && !blocked |=> id_pend_r ##[0:8] tx_valid)
        else $error("identity not offered on activation");
    win_range_a: assert property (
        win_r >= alcc_pkg::WIN_MIN && win_r <= alcc_pkg::WIN_DEF)
        else $error("window size out of range");
    cover_rpt_c: cover property (rpt_hit ##[1:8] load);
    cover_low_c: cover property (low_hit);
    cover_rl_c: cover property (rx_valid && rx_first_r && rx_data[7]);
endmodule
`default_nettype wire

// File: shared/alcc_pkg.sv
package alcc_pkg;
    // ========================================
    // register map and reset values
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_IDENT = 8'h04;
    localparam logic [7:0] OFF_CAP = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_ENC = 8'h10;
    localparam logic [7:0] OFF_WIN = 8'h14;
    localparam logic [15:0] IDENT_RST = 16'h0000;
    localparam logic [1:0] CAP_RST = 2'h0;
    localparam logic [2:0] WIN_DEF = 3'h4;
    localparam logic [2:0] WIN_MIN = 3'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ========================================
    // link control byte coding
    localparam logic [2:0] ACTIV_PREFIX = 3'h3;
    localparam int RPT_BIT = 4;
    localparam int INFO_BIT = 3;
    localparam logic [2:0] CMD_READY = 3'h0;
    localparam logic [2:0] CMD_IDENT = 3'h1;
    localparam logic [2:0] CMD_POWER = 3'h2;
    localparam logic [7:0] PWR_LOW = 8'h00;
    localparam logic [5:0] CAP_RSV = 6'h00;
    localparam logic [1:0] K_NONE = 2'h0;
    localparam logic [1:0] K_INFO = 2'h1;
    localparam logic [1:0] K_SUP = 2'h2;
    localparam logic [1:0] K_UNNUM = 2'h3;
    // ========================================
    // carriers
    typedef struct packed {
        logic [1:0] kind;
        logic [2:0] ns;
        logic [2:0] nr;
        logic [1:0] stype;
        logic [4:0] modif;
    } alcc_rl_t;
    typedef struct packed {
        logic sess;
        logic link_up;
        logic with_cap;
    } alcc_ctrl_t;
    localparam alcc_ctrl_t CTRL_RST = 3'h0;
    localparam alcc_rl_t RL_RST = 15'h0000;
    // ========================================
    // reliable-link control byte codec
    function automatic logic [7:0] rl_encode(alcc_rl_t f);
        logic [7:0] b;
        b = 8'h00;
        unique case (f.kind)
            K_INFO: b = {2'h2, f.ns, f.nr};
            K_SUP: b = {3'h6, f.stype, f.nr};
            K_UNNUM: b = {3'h7, f.modif};
            default: b = 8'h00;
        endcase
        return b;
    endfunction
    function automatic alcc_rl_t rl_decode(logic [7:0] b);
        alcc_rl_t f;
        f = RL_RST;
        if (b[7] && !b[6]) begin
            f.kind = K_INFO;
            f.ns = b[5:3];
            f.nr = b[2:0];
        end else if (b[7] && !b[5]) begin
            f.kind = K_SUP;
            f.stype = b[4:3];
            f.nr = b[2:0];
        end else if (b[7]) begin
            f.kind = K_UNNUM;
            f.modif = b[4:0];
        end
        return f;
    endfunction
endpackage

// File: sim/alcc_fe_model.sv
`timescale 1ns/100ps
`default_nettype none
module alcc_fe_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // card to front-end
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    // front-end to card
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    // scenario control and results
    input wire logic slow,
    input wire logic [15:0] ref_id,
    output logic id_ok,
    output logic [7:0] cap_seen
);
    logic [7:0] got[$];
    logic [7:0] cur[$];
    int frames;
    initial begin
        frames = 0;
        id_ok = 1'b0;
        cap_seen = 8'h00;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
    end
    // ========================================
    // receive side
    // slow mode stalls every other cycle
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
    end
    // repeat flag never looked at here
    always @(posedge ref_clk) begin
        if (reset_n && tx_valid && tx_ready) begin
            got.push_back(tx_data);
            cur.push_back(tx_data);
            if (tx_last) begin
                frames++;
                if (cur[0][3]) cap_seen <= cur[cur.size() - 1];
                if (cur[0][2:0] == alcc_pkg::CMD_IDENT && cur.size() > 2)
                    id_ok <= ({cur[1], cur[2]} == ref_id);
                cur.delete();
            end
        end
    end
    // ========================================
    // send side
    // released line shows the inverse of the last byte
    task automatic send(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            rx_valid <= 1'b1;
            rx_data <= (i == 0) ? v[15:8] : v[7:0];
            rx_last <= (i == n - 1);
        end
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        rx_last <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb;
    logic ref_clk, reset_n, link_activated, low_power_mode, slow, id_ok;
    logic [7:0] awaddr, araddr, rx_data, tx_data, cap_seen;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, rx_valid, rx_last;
    logic tx_valid, tx_last, tx_ready;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] ref_id;
    int failures, checked;
    localparam logic [14:0] FLD [3] = '{{2'h1, 3'h5, 3'h3, 2'h0, 5'h00},
        {2'h3, 3'h0, 3'h0, 2'h0, 5'h19}, {2'h2, 3'h0, 3'h6, 2'h2, 5'h00}};
    localparam logic [7:0] BYT [3] = '{8'hAB, 8'hF9, 8'hD6};
    alcc_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .link_activated(link_activated), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .low_power_mode(low_power_mode));
    alcc_fe_model u_fe (.ref_clk(ref_clk), .reset_n(reset_n),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .slow(slow), .ref_id(ref_id), .id_ok(id_ok),
        .cap_seen(cap_seen));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ========================================
    // bus tasks
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // ========================================
    // link helpers
    task automatic clear();
        u_fe.got.delete();
        u_fe.frames = 0;
    endtask
    task automatic expect_frame(input logic [31:0] e, input int n);
        for (int k = 0; k < 200 && u_fe.frames == 0; k++) @(posedge ref_clk);
        // let the model's end-of-frame results settle first
        @(negedge ref_clk);
        `CHK(u_fe.got.size(), n)
        for (int i = 0; i < n; i++) `CHK(u_fe.got[i], e[31 - 8 * i -: 8])
        clear();
    endtask
    task automatic expect_quiet();
        repeat (20) @(posedge ref_clk);
        `CHK(u_fe.frames, 0)
        clear();
    endtask
    // ========================================
    // scenarios
    task automatic t_regs();
        axi_rd(alcc_pkg::OFF_STAT);
        `CHK(rd, 32'h00000000)
        axi_rd(alcc_pkg::OFF_WIN);
        `CHK(rd[2:0], alcc_pkg::WIN_DEF)
        `CHK(resp, alcc_pkg::RESP_OKAY)
        for (int i = 1; i < 6; i++) begin
            axi_wr(alcc_pkg::OFF_WIN, i);
            axi_rd(alcc_pkg::OFF_WIN);
            `CHK(rd[2:0], (i > 1 && i < 5) ? i[2:0] : 3'h4)
        end
        axi_wr(8'h20, 32'h0000FFFF);
        `CHK(resp, alcc_pkg::RESP_SLVERR)
        axi_rd(8'h20);
        `CHK(resp, alcc_pkg::RESP_SLVERR)
        $display("test regs finished");
    endtask
    task automatic t_ident();
        axi_wr(alcc_pkg::OFF_CTRL, 32'h1);
        expect_frame(32'h60000000, 1);
        slow <= 1'b1;
        ref_id <= 16'hA5C3;
        axi_wr(alcc_pkg::OFF_IDENT, 32'hA5C3);
        `CHK(resp, alcc_pkg::RESP_OKAY)
        axi_wr(alcc_pkg::OFF_CAP, 32'h1);
        axi_wr(alcc_pkg::OFF_CTRL, 32'h6);
        expect_frame(32'h69A5C301, 4);
        `CHK(id_ok, 1'b1)
        `CHK(cap_seen, 8'h01)
        axi_wr(alcc_pkg::OFF_CAP, 32'h2);
        axi_wr(alcc_pkg::OFF_CTRL, 32'h5);
        expect_frame(32'h68020000, 2);
        `CHK(cap_seen, 8'h02)
        axi_wr(alcc_pkg::OFF_CTRL, 32'h0);
        ref_id <= 16'h1234;
        slow <= 1'b0;
        link_activated <= 1'b1;
        @(posedge ref_clk);
        link_activated <= 1'b0;
        expect_frame(32'h61A5C300, 3);
        `CHK(id_ok, 1'b0)
        u_fe.send(16'h7000, 1);
        expect_frame(32'h61A5C300, 3);
        u_fe.send(16'h6800, 1);
        expect_quiet();
        $display("test ident finished");
    endtask
    task automatic t_power();
        u_fe.send(16'h6201, 2);
        repeat (3) @(posedge ref_clk);
        `CHK(low_power_mode, 1'b0)
        u_fe.send(16'h6500, 1);
        axi_rd(alcc_pkg::OFF_STAT);
        `CHK(rd[18], 1'b1)
        expect_quiet();
        axi_wr(alcc_pkg::OFF_CTRL, 32'h9);
        u_fe.send(16'h7000, 1);
        u_fe.send(16'h6200, 2);
        axi_wr(alcc_pkg::OFF_CTRL, 32'h0);
        expect_quiet();
        `CHK(low_power_mode, 1'b0)
        axi_wr(alcc_pkg::OFF_CTRL, 32'h11);
        u_fe.send(16'h7000, 1);
        axi_wr(alcc_pkg::OFF_CTRL, 32'h0);
        expect_quiet();
        u_fe.send(16'h6200, 2);
        repeat (3) @(posedge ref_clk);
        `CHK(low_power_mode, 1'b1)
        axi_rd(alcc_pkg::OFF_STAT);
        `CHK(rd[0], 1'b1)
        $display("test power finished");
    endtask
    task automatic t_codec();
        for (int i = 0; i < 3; i++) begin
            axi_wr(alcc_pkg::OFF_ENC, {9'h000, FLD[i], 8'h00});
            axi_rd(alcc_pkg::OFF_ENC);
            `CHK(rd[7:0], BYT[i])
            u_fe.send({BYT[i], 8'h00}, 1);
            repeat (3) @(posedge ref_clk);
            axi_rd(alcc_pkg::OFF_STAT);
            `CHK(rd[16:2], FLD[i])
        end
        $display("test codec finished");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #300000;
        failures++;
        results();
    end
    initial begin
        {reset_n, link_activated, slow, awvalid, wvalid, bready} = 6'h00;
        {arvalid, rready, awaddr, araddr, wdata, ref_id} = 66'h0;
        wstrb = 4'hF;
        failures = 0;
        checked = 0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_regs();
        t_ident();
        t_power();
        t_codec();
        results();
    end
endmodule
`default_nettype wire
